// ===== hdl/isc_pkg.sv
package isc_pkg;

  // Widths
  localparam int PIX_W  = 12;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 32;

  // Embedded timing reference codes
  localparam logic [31:0] SAV_CODE    = 32'hff000080;
  localparam logic [31:0] EAV_CODE    = 32'hff00009d;
  localparam logic [23:0] CODE_PREFIX = 24'hff0000;
  // Bytes still in the history pipe right after a start code
  localparam logic [1:0]  SAV_SKIP    = 2'h3;

  // Image size limits
  localparam logic [11:0] MAX_RES    = 12'h800;
  localparam logic [11:0] PREV_MAX_W = 12'h280;
  localparam logic [11:0] PREV_MAX_H = 12'h1e0;

  // Reset values
  localparam logic [1:0]  SYNC_RST  = 2'h0;
  localparam logic [2:0]  PCK_RST   = 3'h0;
  localparam logic [23:0] HIST_RST  = 24'h000000;
  localparam logic [31:0] WORD_RST  = 32'h00000000;
  localparam logic [11:0] IDX_RST   = 12'h000;

  typedef enum logic [1:0] {
    ISC_FMT_YCBCR  = 2'b00,
    ISC_FMT_RGB888 = 2'b01,
    ISC_FMT_RGB565 = 2'b10
  } isc_fmt_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_BLANK  = 3'b001,
    ST_LDELAY = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_LGAP   = 3'b100
  } isc_state_t;

  typedef struct packed {
    logic       embedded_sync;
    logic       frame_sync_active_low;
    logic       line_sync_active_low;
    logic       pck_falling_edge;
    logic       capture_enable;
    logic       codec_on;
    logic       gray_mode;
    logic       gray_pack_mode;
    isc_fmt_t   fmt;
    logic [2:0] frame_skip;
    logic [7:0] start_frame_delay_lines;
    logic [9:0] start_line_delay_cycles;
  } isc_cfg_t;

  typedef struct packed {
    logic        first;
    logic [31:0] data;
  } isc_word_t;

  typedef struct packed {
    logic frame_start;
    logic frame_done;
    logic sav;
    logic eav;
    logic overrun;
  } isc_event_t;

endpackage

// ===== hdl/isc_pair_buffer.sv
module isc_pair_buffer #(
  parameter int WIDTH = 33
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic             spare_valid;
  logic [WIDTH-1:0] spare_data;
  logic             push;
  logic             pop;

  // Accept only while the spare slot is free
  assign in_ready = !spare_valid;
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  // Head slot drives the output, spare slot absorbs a stall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid   <= 1'b0;
      out_data    <= '0;
      spare_valid <= 1'b0;
      spare_data  <= '0;
    end else if (pop && spare_valid) begin
      out_data    <= spare_data;
      spare_valid <= 1'b0;
    end else if (pop) begin
      out_valid <= push;
      out_data  <= in_data;
    end else if (push && !out_valid) begin
      out_valid <= 1'b1;
      out_data  <= in_data;
    end else if (push) begin
      spare_valid <= 1'b1;
      spare_data  <= in_data;
    end
  end

endmodule

// ===== hdl/isc_capture.sv
// Operation
// R1: Frames sync by dedicated pins or embedded codes; pins ignored in embedded mode.
// R2: Software selects active polarity of frame and line sync pulses.
// R3: Pixel bus up to 12 bits, sampled on active pixel clock edge.
// R4: Pin mode captures after programmed blank lines, then programmed clock delay.
// R5: Embedded mode recognises start code ff000080 opening each video block.
// R6: Embedded mode recognises end code ff00009d closing each video block.
// R7: Embedded mode keeps only active video, drops blanking and code bytes.
// R8: Sensor must send at least one vertical blanking line per frame.
// R9: Events at each frame start and at each DMA frame completion.
// R10: Event on every detected reference code in embedded mode; code raises events only for start and end codes.
// R11: Color input accepts YCbCr 4:2:2, RGB 8:8:8 and RGB 5:6:5.
// R12: Codec path receives data only while codec enable is one.
// R13: Software should enable codec path only while capture is needed.
// R14: Gray samples stored raw, one or two per word by pack mode.
// R15: Codec path unavailable while grayscale input is selected.
// R16: Frame rate counter keeps every frame or one of N, N 2..8.
// R17: Input images up to 2048 by 2048 pixels accepted.
// R18: Preview output limited to 640 by 480 pixels.
// R19: Preview output in display RGB format, 5:6:5 reduced to 5:5:5; code converts only 5:6:5, others pass unchanged.
// R20: Separate buffers on preview and codec paths before DMA.
// R21: Master clock driven to sensor; sensor returns pixel clock.
// R22: System clock must run faster than the sensor pixel clock.
// R23: Pixel domain events synchronised into system clock before flags raise.
module isc_capture
  import isc_pkg::*;
#(
  parameter int MCLK_HALF_DIV = 1
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire isc_cfg_t          cfg,
  input  wire logic              dma_frame_done,
  input  wire logic              sensor_pixel_clock_in,
  input  wire logic              frame_sync_in,
  input  wire logic              line_sync_in,
  input  wire logic [PIX_W-1:0]  sensor_pixel_bus,
  output logic                   sensor_master_clock_out,
  output isc_word_t              preview_word,
  output logic                   preview_valid,
  input  wire logic              preview_ready,
  output isc_word_t              codec_word,
  output logic                   codec_valid,
  input  wire logic              codec_ready,
  output isc_event_t             events,
  output logic                   capture_busy
);

  logic [2:0]       pck_sync;
  logic [1:0]       fs_sync;
  logic [1:0]       ls_sync;
  logic [PIX_W-1:0] bus_s1;
  logic [PIX_W-1:0] bus_s2;
  logic             pix_edge;
  logic             frame_lvl;
  logic             line_lvl;
  logic             frame_lvl_d;
  logic             line_lvl_d;
  logic             fs_rise;
  logic             ls_rise;
  logic             ls_fall;
  isc_state_t       state;
  logic [7:0]       line_cnt;
  logic [9:0]       dly;
  logic             pin_take;
  logic [23:0]      hist;
  logic [31:0]      code_word;
  logic             is_sav;
  logic             is_eav;
  logic             is_other;
  logic             emb_active;
  logic             vblank_seen;
  logic [1:0]       emb_cnt;
  logic             emb_take;
  logic             emb_edge;
  logic             start_evt;
  logic             line_start;
  logic             line_end;
  logic [2:0]       frame_count;
  logic             in_frame;
  logic             take;
  logic [PIX_W-1:0] sample;
  logic [11:0]      pix_idx;
  logic [11:0]      line_idx;
  logic [1:0]       bpp_cnt;
  logic             pix_last;
  logic             in_res;
  logic [31:0]      acc;
  logic [1:0]       pos;
  logic             word_done;
  logic [31:0]      next_word;
  logic             first_pending;
  logic             wr_valid;
  logic             wr_prev_ok;
  logic             wr_first;
  logic [31:0]      wr_data;
  logic [31:0]      wr_prev_data;
  logic             prev_in_valid;
  logic             prev_in_ready;
  logic             codec_in_valid;
  logic             codec_in_ready;
  logic [7:0]       mclk_cnt;

  // Two-flop synchronisers on every sensor pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pck_sync <= PCK_RST;
      fs_sync  <= SYNC_RST;
      ls_sync  <= SYNC_RST;
      bus_s1   <= '0;
      bus_s2   <= '0;
    end else begin
      pck_sync <= {pck_sync[1:0], sensor_pixel_clock_in};
      fs_sync  <= {fs_sync[0], frame_sync_in};
      ls_sync  <= {ls_sync[0], line_sync_in};
      bus_s1   <= sensor_pixel_bus;
      bus_s2   <= bus_s1;
    end
  end

  // Active pixel clock edge and sync levels after polarity
  assign pix_edge  = cfg.pck_falling_edge ? (!pck_sync[1] && pck_sync[2])
                                          : (pck_sync[1] && !pck_sync[2]); // [R3]
  assign frame_lvl = fs_sync[1] ^ cfg.frame_sync_active_low; // [R2]
  assign line_lvl  = ls_sync[1] ^ cfg.line_sync_active_low; // [R2]
  assign fs_rise   = pix_edge && !cfg.embedded_sync && frame_lvl && !frame_lvl_d; // [R1]
  assign ls_rise   = pix_edge && !cfg.embedded_sync && line_lvl && !line_lvl_d;
  assign ls_fall   = pix_edge && !cfg.embedded_sync && !line_lvl && line_lvl_d;

  // Sync levels as seen at the previous pixel edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_lvl_d <= 1'b0;
      line_lvl_d  <= 1'b0;
    end else if (pix_edge) begin
      frame_lvl_d <= frame_lvl;
      line_lvl_d  <= line_lvl;
    end
  end

  // Pin sync sequencer: blank lines, then line delay, then active
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      line_cnt <= 8'h00;
      dly      <= 10'h000;
    end else if (cfg.embedded_sync) begin
      state <= ST_IDLE; // [R1]
    end else if (fs_rise) begin
      state    <= ST_BLANK;
      line_cnt <= 8'h00;
    end else if (pix_edge) begin
      case (state)
        ST_BLANK: begin
          if (ls_rise && line_cnt == cfg.start_frame_delay_lines) begin
            state <= (cfg.start_line_delay_cycles == 10'h000) ? ST_ACTIVE : ST_LDELAY; // [R4]
            dly   <= 10'h001;
          end else if (ls_rise) begin
            line_cnt <= line_cnt + 8'h01;
          end
        end
        ST_LDELAY: begin
          if (!line_lvl) begin
            state <= ST_LGAP;
          end else if (dly == cfg.start_line_delay_cycles) begin
            state <= ST_ACTIVE; // [R4]
          end else begin
            dly <= dly + 10'h001;
          end
        end
        ST_ACTIVE: begin
          if (!line_lvl) begin
            state <= ST_LGAP;
          end
        end
        ST_LGAP: begin
          if (ls_rise) begin
            state <= (cfg.start_line_delay_cycles == 10'h000) ? ST_ACTIVE : ST_LDELAY;
            dly   <= 10'h001;
          end
        end
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Sample while the line is high and the delay has run out
  assign pin_take = pix_edge && !cfg.embedded_sync && line_lvl &&
                    (state == ST_ACTIVE ||
                     (state == ST_LDELAY && dly == cfg.start_line_delay_cycles) ||
                     (ls_rise && cfg.start_line_delay_cycles == 10'h000 &&
                      (state == ST_LGAP || (state == ST_BLANK &&
                       line_cnt == cfg.start_frame_delay_lines)))); // [R4] Rise edge is period 0

  // Embedded code recognition over the last four bytes
  assign emb_edge  = pix_edge && cfg.embedded_sync;
  assign code_word = {hist, bus_s2[BYTE_W-1:0]};
  assign is_sav    = code_word == SAV_CODE; // [R5]
  assign is_eav    = code_word == EAV_CODE; // [R6]
  assign is_other  = hist == CODE_PREFIX && !is_sav && !is_eav;

  // Byte history, active window and blanking tracker
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist        <= HIST_RST;
      emb_active  <= 1'b0;
      vblank_seen <= 1'b0;
      emb_cnt     <= 2'h0;
    end else if (!cfg.embedded_sync) begin
      emb_active  <= 1'b0;
      vblank_seen <= 1'b0;
    end else if (emb_edge) begin
      hist <= code_word[23:0];
      if (is_sav) begin
        emb_active  <= 1'b1; // [R5]
        emb_cnt     <= 2'h0;
        vblank_seen <= 1'b0; // [R8]
      end else if (is_eav) begin
        emb_active <= 1'b0; // [R6]
      end else begin
        if (is_other) begin
          vblank_seen <= 1'b1;
        end
        if (emb_active && emb_cnt != SAV_SKIP) begin
          emb_cnt <= emb_cnt + 2'h1;
        end
      end
    end
  end

  // Emit the oldest history byte once the start code has left the pipe
  assign emb_take = emb_edge && emb_active && emb_cnt == SAV_SKIP && !is_eav; // [R7]

  // Frame and line boundaries from either sync method
  assign start_evt  = fs_rise || (emb_edge && is_sav && vblank_seen); // [R9]
  assign line_start = ls_rise || (emb_edge && is_sav);
  assign line_end   = (ls_fall && in_frame) || (emb_edge && is_eav);

  // Frame rate counter picks one frame in frame_skip+1
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_count <= 3'h0;
      in_frame    <= 1'b0;
    end else if (start_evt) begin
      in_frame    <= cfg.capture_enable && frame_count == 3'h0; // [R16]
      frame_count <= (frame_count >= cfg.frame_skip) ? 3'h0 : frame_count + 3'h1;
    end else if (!cfg.capture_enable) begin
      in_frame <= 1'b0;
    end
  end

  assign take   = in_frame && (cfg.embedded_sync ? emb_take : pin_take);
  assign sample = cfg.embedded_sync ? {4'h0, hist[23:16]} : bus_s2;

  // Pixel and line position, bytes per pixel by format
  assign pix_last = cfg.gray_mode ||
                    bpp_cnt == ((cfg.fmt == ISC_FMT_RGB888) ? 2'h2 : 2'h1); // [R11]
  assign in_res   = pix_idx < MAX_RES && line_idx < MAX_RES; // [R17]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_idx  <= IDX_RST;
      line_idx <= IDX_RST;
      bpp_cnt  <= 2'h0;
    end else if (start_evt) begin
      pix_idx  <= IDX_RST;
      line_idx <= IDX_RST;
      bpp_cnt  <= 2'h0;
    end else if (line_start) begin
      pix_idx <= IDX_RST;
      bpp_cnt <= 2'h0;
    end else if (line_end) begin
      if (line_idx != MAX_RES) begin
        line_idx <= line_idx + 12'h001;
      end
    end else if (take && in_res) begin
      bpp_cnt <= pix_last ? 2'h0 : bpp_cnt + 2'h1;
      if (pix_last) begin
        pix_idx <= pix_idx + 12'h001;
      end
    end
  end

  // Word packing: four color bytes, or gray samples left aligned
  always_comb begin
    next_word = acc;
    word_done = 1'b0;
    if (cfg.gray_mode && cfg.gray_pack_mode) begin
      next_word = {sample, 4'h0, 16'h0000}; // [R14]
      word_done = 1'b1;
    end else if (cfg.gray_mode) begin
      next_word = {acc[31:16], sample, 4'h0}; // [R14]
      word_done = pos != 2'h0;
    end else begin
      case (pos)
        2'h0:    next_word = {sample[7:0], acc[23:0]};
        2'h1:    next_word = {acc[31:24], sample[7:0], acc[15:0]};
        2'h2:    next_word = {acc[31:16], sample[7:0], acc[7:0]};
        default: next_word = {acc[31:8], sample[7:0]};
      endcase
      word_done = pos == 2'h3;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc           <= WORD_RST;
      pos           <= 2'h0;
      first_pending <= 1'b0;
    end else if (start_evt) begin
      pos           <= 2'h0;
      first_pending <= 1'b1;
    end else if (take && in_res) begin
      if (cfg.gray_mode && !word_done) begin
        acc <= {sample, 4'h0, 16'h0000};
        pos <= 2'h2;
      end else if (word_done) begin
        pos           <= 2'h0;
        first_pending <= 1'b0;
      end else begin
        acc <= next_word;
        pos <= pos + 2'h1;
      end
    end
  end

  // Completed word with its preview window verdict
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid   <= 1'b0;
      wr_prev_ok <= 1'b0;
      wr_first   <= 1'b0;
      wr_data    <= WORD_RST;
    end else begin
      wr_valid   <= take && in_res && word_done; // [R17]
      wr_prev_ok <= pix_idx < PREV_MAX_W && line_idx < PREV_MAX_H; // [R18]
      wr_first   <= first_pending;
      wr_data    <= next_word;
    end
  end

  // Preview gets 5:5:5 from 5:6:5 by dropping the green low bit
  assign wr_prev_data = (!cfg.gray_mode && cfg.fmt == ISC_FMT_RGB565) ?
    {1'b0, wr_data[31:27], wr_data[26:22], wr_data[20:16],
     1'b0, wr_data[15:11], wr_data[10:6], wr_data[4:0]} : wr_data; // [R19]

  assign prev_in_valid  = wr_valid && wr_prev_ok;
  assign codec_in_valid = wr_valid && cfg.codec_on && !cfg.gray_mode; // [R12] [R15]

  // Per-path buffers ahead of DMA
  isc_pair_buffer #(.WIDTH($bits(isc_word_t))) u_prev_buf ( // [R20]
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (prev_in_valid),
    .in_ready  (prev_in_ready),
    .in_data   ({wr_first, wr_prev_data}),
    .out_valid (preview_valid),
    .out_ready (preview_ready),
    .out_data  (preview_word)
  );

  isc_pair_buffer #(.WIDTH($bits(isc_word_t))) u_codec_buf ( // [R20]
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (codec_in_valid),
    .in_ready  (codec_in_ready),
    .in_data   ({wr_first, wr_data}),
    .out_valid (codec_valid),
    .out_ready (codec_ready),
    .out_data  (codec_word)
  );

  // Event pulses; frame_start, sav and eav derived from synchronised samples
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      events       <= '0;
      capture_busy <= 1'b0;
    end else begin
      events.frame_start <= start_evt; // [R9] [R23]
      events.frame_done  <= dma_frame_done; // [R9]
      events.sav         <= emb_edge && is_sav; // [R10] [R23]
      events.eav         <= emb_edge && is_eav; // [R10]
      events.overrun     <= (prev_in_valid && !prev_in_ready) ||
                            (codec_in_valid && !codec_in_ready);
      capture_busy       <= in_frame;
    end
  end

  // Sensor master clock divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt                <= 8'h00;
      sensor_master_clock_out <= 1'b0;
    end else if (mclk_cnt == 8'(MCLK_HALF_DIV - 1)) begin
      mclk_cnt                <= 8'h00;
      sensor_master_clock_out <= !sensor_master_clock_out; // [R21]
    end else begin
      mclk_cnt <= mclk_cnt + 8'h01;
    end
  end

  chk_pins_unused: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    (cfg.embedded_sync && !(emb_edge && is_sav)) |=> !events.frame_start)
    else $error("pin frame start in embedded mode");
  chk_frame_pol: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    (pix_edge && !cfg.embedded_sync && (fs_sync[1] ^ cfg.frame_sync_active_low)
     && !frame_lvl_d) |=> events.frame_start) else $error("frame start missed");
  chk_blank_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (state == ST_BLANK && ls_rise && !fs_rise && !cfg.embedded_sync &&
     line_cnt != cfg.start_frame_delay_lines) |=> state == ST_BLANK)
    else $error("left blanking early");
  chk_sav_event: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (emb_edge && is_sav) |=> (events.sav && emb_active))
    else $error("start code not flagged");
  chk_eav_close: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (emb_edge && is_eav) |=> (!emb_active && events.eav))
    else $error("end code did not close window");
  chk_code_bytes: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    (emb_active && emb_cnt != SAV_SKIP) |-> !emb_take)
    else $error("code byte captured");
  chk_codec_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (!cfg.codec_on || cfg.gray_mode) |-> !codec_in_valid)
    else $error("codec fed while off");
  chk_gray_codec: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
    (cfg.gray_mode && $stable(cfg.gray_mode)) |=> !codec_in_valid)
    else $error("codec fed in gray mode");
  chk_skip_frame: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
    (start_evt && frame_count != 3'h0) |=> !in_frame)
    else $error("skipped frame captured");
  chk_res_drop: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R17]
    (take && !in_res) |=> !wr_valid) else $error("word beyond size limit");
  chk_prev_limit: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R18]
    (take && word_done && pix_idx >= PREV_MAX_W) |=> !prev_in_valid)
    else $error("preview beyond width limit");
  chk_done_event: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    dma_frame_done |=> events.frame_done) else $error("frame done not flagged");
  chk_mclk_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R21]
    (mclk_cnt == 8'(MCLK_HALF_DIV - 1)) |=> $changed(sensor_master_clock_out))
    else $error("master clock stuck");

endmodule

// ===== bench/isc_sensor_model.sv
// Behavioural sensor: pixel clock runs only while a task drives pixels, syncs follow polarity
module isc_sensor_model (
  output logic        pclk,
  output logic        fsync,
  output logic        lsync,
  output logic [11:0] bus,
  input  wire logic   fs_low,
  input  wire logic   ls_low,
  input  wire logic   pck_fall
);
  timeunit 1ns;
  timeprecision 1ns;

  logic f_on = 1'b0;
  logic l_on = 1'b0;
  logic clk_q;

  // Idle clock level follows the sampling edge, so data always leads it
  assign pclk = clk_q ^ pck_fall;

  // Sync pins show their active level as the polarity asks
  assign fsync = f_on ^ fs_low;
  assign lsync = l_on ^ ls_low;

  initial begin
    clk_q = 1'b0;
    bus   = 12'h000;
  end

  // One pixel period: data set half a period ahead of the active edge
  task automatic pix(input logic [11:0] d);
    bus = d;
    #160 clk_q = 1'b1;
    #160 clk_q = 1'b0;
    bus = ~d; // Released bus shows the inverse of its last value
  endtask

  // Frame with one blanking line, then one active line
  task automatic pin_frame(input logic [11:0] q [$]);
    f_on = 1'b1;
    pix(12'h000);
    l_on = 1'b1;
    pix(12'h0aa);
    l_on = 1'b0;
    pix(12'h0aa);
    l_on = 1'b1;
    foreach (q[i]) pix(q[i]);
    l_on = 1'b0;
    pix(12'h000);
    f_on = 1'b0;
    pix(12'h000);
  endtask

  // Raw byte stream for embedded code sync
  task automatic stream(input logic [11:0] q [$]);
    foreach (q[i]) pix(q[i]);
  endtask
endmodule

// ===== bench/tb_top.sv
module tb_top
  import isc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;
  logic        rst_n;
  logic        dma_frame_done;
  logic        preview_ready;
  logic        codec_ready;
  isc_cfg_t    cfg;
  logic        pclk;
  logic        fsync;
  logic        lsync;
  logic [11:0] pbus;
  logic        mclk;
  logic        busy;
  isc_word_t   pw;
  isc_word_t   cw;
  logic        pv;
  logic        cv;
  isc_event_t  ev;
  int          miscompares;
  int          check_count;
  int          n_fs;
  int          n_sav;
  int          n_eav;
  int          n_ovr;
  int          n_fd;
  int          n_mck;
  isc_word_t   pq [$];
  isc_word_t   cq [$];

  isc_capture uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .dma_frame_done(dma_frame_done),
    .sensor_pixel_clock_in(pclk), .frame_sync_in(fsync), .line_sync_in(lsync),
    .sensor_pixel_bus(pbus), .sensor_master_clock_out(mclk), .preview_word(pw),
    .preview_valid(pv), .preview_ready(preview_ready), .codec_word(cw), .codec_valid(cv),
    .codec_ready(codec_ready), .events(ev), .capture_busy(busy)
  );

  isc_sensor_model sensor (
    .pclk(pclk), .fsync(fsync), .lsync(lsync), .bus(pbus),
    .fs_low(cfg.frame_sync_active_low), .ls_low(cfg.line_sync_active_low),
    .pck_fall(cfg.pck_falling_edge)
  );

  // System clock, far above the pixel clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Collect accepted words and event pulses
  always @(posedge ref_clk) begin
    if (pv === 1'b1 && preview_ready === 1'b1) pq.push_back(pw);
    if (cv === 1'b1 && codec_ready === 1'b1) cq.push_back(cw);
    n_fs  += (ev.frame_start === 1'b1);
    n_sav += (ev.sav === 1'b1);
    n_eav += (ev.eav === 1'b1);
    n_ovr += (ev.overrun === 1'b1);
    n_fd  += (ev.frame_done === 1'b1);
    n_mck += (mclk !== $past(mclk));
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_words(input int n);
    int k;
    for (k = 0; k < 400 && pq.size() < n; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    if (k == 400) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // One blank line, two-edge line delay, every frame kept
  task automatic setup(input logic emb, input logic low, input logic gray, input logic codec,
                       input logic rdy);
    @(posedge ref_clk);
    cfg <= '{emb, low, low, 1'b0, 1'b1, codec, gray, 1'b1, ISC_FMT_YCBCR, 3'h0, 8'h01, 10'h002};
    preview_ready <= rdy;
    repeat (2) @(negedge ref_clk);
    {n_fs, n_sav, n_eav, n_ovr, n_fd} = '0;
    pq.delete();
    cq.delete();
  endtask

  // Pin sync, both polarities; codec only on the active-high pass
  task automatic pin_test(input logic low);
    setup(1'b0, low, 1'b0, ~low, 1'b1);
    sensor.pin_frame('{12'h0ee, 12'h0ee, 12'h511, 12'h022, 12'h033, 12'h044,
                       12'h055, 12'h066, 12'h077, 12'h088});
    wait_words(2);
    check(pq[0], {1'b1, 32'h11223344});
    check(pq[1], {1'b0, 32'h55667788});
    check(n_fs, 1);
    check(busy, 1'b1);
    check(cq.size(), low ? 0 : 2);
    if (!low) check(cq[0], {1'b1, 32'h11223344});
  endtask

  // Embedded codes: blank code, start, four bytes, end
  task automatic code_test();
    setup(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    sensor.stream('{12'h0ff, 12'h000, 12'h000, 12'h0ab,
                    12'h0ff, 12'h000, 12'h000, 12'h080, 12'h0a1, 12'h0b2, 12'h0c3,
                    12'h0d4, 12'h0ff, 12'h000, 12'h000, 12'h09d, 12'h010, 12'h010});
    wait_words(1);
    check(pq.size(), 1);
    check(pq[0], {1'b1, 32'ha1b2c3d4});
    check(n_sav, 1);
    check(n_eav, 1);
    check(n_fs, 1);
  endtask

  // Gray one-per-word with a stalled preview side: third word overruns
  task automatic gray_test();
    setup(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    sensor.pin_frame('{12'h0ee, 12'h0ee, 12'habc, 12'h123, 12'h456});
    check(n_ovr, 1);
    @(posedge ref_clk);
    preview_ready <= 1'b1;
    wait_words(2);
    check(pq.size(), 2);
    check(pq[0], {1'b1, 32'habc00000});
    check(pq[1], {1'b0, 32'h12300000});
    check(cq.size(), 0);
    @(posedge ref_clk);
    dma_frame_done <= 1'b1;
    @(posedge ref_clk);
    dma_frame_done <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(n_fd, 1);
    check(n_mck > 100, 1);
    @(posedge ref_clk);
    cfg.gray_pack_mode <= 1'b0;
    @(negedge ref_clk);
    sensor.pin_frame('{12'h0ee, 12'h0ee, 12'habc, 12'h123});
    wait_words(3);
    check(pq[2], {1'b1, 32'habc01230});
  endtask

  // RGB 5:6:5 on falling pixel edges, one frame in two kept
  task automatic rgb_test();
    setup(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    @(posedge ref_clk);
    cfg.pck_falling_edge <= 1'b1;
    cfg.fmt              <= ISC_FMT_RGB565;
    cfg.frame_skip       <= 3'h1;
    @(negedge ref_clk);
    repeat (2) sensor.pin_frame('{12'h0ee, 12'h0ee, 12'h0f8, 12'h000, 12'h000, 12'h03f});
    wait_words(1);
    check(pq.size(), 1);
    check(pq[0], {1'b1, 32'h7c00001f});
    check(cq.size(), 1);
    check(cq[0], {1'b1, 32'hf800003f});
    check(n_fs, 2);
    check(busy, 1'b0);
  endtask

  // Reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    dma_frame_done = 1'b0;
    preview_ready = 1'b1;
    codec_ready = 1'b1;
    cfg = '0;
    {miscompares, check_count, n_mck} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    pin_test(1'b0);
    pin_test(1'b1);
    code_test();
    gray_test();
    rgb_test();
    print_verdict();
  end
endmodule
